// File: clk_postscale_defines.svh
// register offsets, field positions and timing constants for the postscaler block
`ifndef CLK_POSTSCALE_DEFINES_SVH
`define CLK_POSTSCALE_DEFINES_SVH
// ==========================================
// register map (index, byte address = 4 x index)
`define IDX_PLL_DIVIDE_CONFIG 4'h1
`define IDX_CLOCK_CTRL 4'h0
`define IDX_CLOCK_STATUS 4'h2
`define ADDR_PLL_DIVIDE_CONFIG 6'h04
`define ADDR_CLOCK_CTRL 6'h00
`define ADDR_CLOCK_STATUS 6'h08
// ==========================================
// field positions
`define TRIP_HI 15
`define TRIP_LO 12
`define PDIV_HI 11
`define PDIV_LO 8
`define SRC_HI 1
`define SRC_LO 0
`define LOST_BIT 13
// ==========================================
// reset values and encodings
`define DIVCFG_RESET 8'h00
`define SRC_RESET 2'h1
`define SRC_MASTER 2'h1
`define SRC_PLL 2'h2
// ==========================================
// loss of reference timing and bus response codes
`define LOSS_REF_PERIODS 10
`define PLL_MULT 24
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: clk_postscale_pkg.sv
// types shared by the postscaler block
package clk_postscale_pkg;
    // core clock source select encoding
    typedef enum logic [1:0] {
        src_rsvd0 = 2'b00,
        src_master = 2'b01,
        src_pll = 2'b10,
        src_rsvd3 = 2'b11
    } clk_src_t;
    // divide configuration fields
    typedef struct packed {
        logic [3:0] loss_ref_trip_point;
        logic [3:0] postscale_divide;
    } div_cfg_t;
endpackage

// File: clock_postscaler_loss_ref_trip.sv
// clock postscaler and loss of reference detector with axi4-lite registers
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "clk_postscale_defines.svh"
// ==========================================
// Summary of operation
// - trip point field in bits fifteen to twelve
// - lost after (trip+1)*10 ref periods over half-multiplier
// - multiplier fixed at twenty-four, divisor twelve
// - postscale divide field in bits eleven to eight
// - postscaler input follows core clock source select
// - codes zero to seven give powers, else 256
// - postscaler output never glitches or runts
// - divide changes accepted while clock runs
// - low byte reserved, reads zero, writes ignored
// - source select 01 master, 10 pll, others reserved
// - lost flag set by hardware, write one clears
// ==========================================
// operating notes
// - clock sources arrive as one-cycle tick enables on aclk
// - core_clk_en pulses once per postscaled core period
// - core_clk_level low in first half, high in second half
// - with divide by one the level stays low, enable follows ticks
// - a new divide code waits for the running period to end
// - so a long old period delays the new ratio by up to 256 ticks
// - if the chosen source stops, a pending ratio stays pending
// - codes with the top bit set give 256 ticks per period
// - the postscaler counter is eight bits wide
// - loss counter runs on pll ticks only, cleared by reference edges
// - counter saturates at its limit, so the flag keeps setting
// - the flag cannot be cleared while the reference is still gone
// - a set in the same cycle as a write-one clear wins
// - reset leaves divide by one, trip zero and master selected
// - reset clears the flag and the postscaler counter
// - register map: control at 0x00, divide at 0x04, status at 0x08
// - other addresses answer slverr and read as zero
// - only bits 15 to 8 of the divide word are kept
// - the low byte always reads back as zero
// - status shows the flag at bit 13, the source in bits 1 to 0
// - source writes of reserved codes leave the selection unchanged
// - lane 1 strobe gates divide and flag bytes, lane 0 the source
// - one write and one read may be outstanding at a time
// - write address and data are taken in either order
// - bvalid rises one cycle after the later of the two is held
// - rvalid rises the cycle after the read address is taken
module clock_postscaler_loss_ref_trip
    import clk_postscale_pkg::*;
#(
    parameter int MULT = `PLL_MULT
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock sources, taken as enables synchronous to aclk
    input wire logic master_clk_tick,
    input wire logic pll_clk_tick,
    input wire logic ref_clk_edge,
    // outputs
    output logic core_clk_en,
    output logic core_clk_level,
    output logic lost_reference_flag
);
    // ==========================================
    // elaboration checks
    initial begin
        if (MULT < 2 || (MULT % 2) != 0) begin
            $error("multiplier must be even and at least two");
        end
    end

    localparam int HALF_MULT = MULT / 2;
    localparam int LIMIT_MAX = 16 * `LOSS_REF_PERIODS * HALF_MULT;
    localparam int CW = $clog2(LIMIT_MAX + 1);

    // loss counter must stay a sane width
    initial begin
        if (CW < 1 || CW > 16) begin
            $error("loss counter width out of range");
        end
    end

    // ==========================================
    // registers
    div_cfg_t cfg_reg;
    clk_src_t src_reg;
    logic lost_reg;
    logic [7:0] pcnt_reg;
    logic [7:0] active_mask_reg;
    logic out_level_reg;
    logic [CW-1:0] lcnt_reg;
    logic have_aw_reg, have_w_reg, bvalid_reg, rvalid_reg;
    logic [5:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    // ==========================================
    // write channel decode
    wire aw_take = s_axi_awvalid && !have_aw_reg && !bvalid_reg;
    wire w_take = s_axi_wvalid && !have_w_reg && !bvalid_reg;
    wire wr_go = have_aw_reg && have_w_reg && !bvalid_reg;
    wire wr_div = wr_go && awaddr_reg == `ADDR_PLL_DIVIDE_CONFIG;
    wire wr_ctl = wr_go && awaddr_reg == `ADDR_CLOCK_CTRL;
    wire wr_sta = wr_go && awaddr_reg == `ADDR_CLOCK_STATUS;
    wire wr_ok = wr_div || wr_ctl || wr_sta;
    // strobe lanes
    wire lane1 = wstrb_reg[1];
    wire lane0 = wstrb_reg[0];
    // reserved low byte never stored
    wire [7:0] div_hi_next = lane1 ? wdata_reg[`TRIP_HI:`PDIV_LO] : cfg_reg;
    // source select checks
    wire [1:0] src_wr = wdata_reg[`SRC_HI:`SRC_LO];
    wire src_ok = src_wr == `SRC_MASTER || src_wr == `SRC_PLL;
    wire lost_clr = wr_sta && lane1 && wdata_reg[`LOST_BIT];

    // write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw_reg <= 1'b0;
            have_w_reg <= 1'b0;
            awaddr_reg <= 6'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                have_aw_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[5:2], 2'b00};
            end else if (wr_go) begin
                have_aw_reg <= 1'b0;
            end
            if (w_take) begin
                have_w_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                have_w_reg <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= `DIVCFG_RESET;
            src_reg <= src_master;
        end else begin
            if (wr_div) begin
                cfg_reg <= div_hi_next;
            end
            if (wr_ctl && lane0 && src_ok) begin
                src_reg <= clk_src_t'(src_wr);
            end
        end
    end

    // ==========================================
    // read channel
    wire rd_take = s_axi_arvalid && !rvalid_reg;
    wire [5:0] raddr = {s_axi_araddr[5:2], 2'b00};
    wire [31:0] rd_div = {16'h0000, cfg_reg, 8'h00};
    wire [31:0] rd_ctl = {30'h0, src_reg};
    wire [31:0] rd_sta = {18'h0, lost_reg, 11'h0, src_reg};
    wire rd_hit_div = raddr == `ADDR_PLL_DIVIDE_CONFIG;
    wire rd_hit_ctl = raddr == `ADDR_CLOCK_CTRL;
    wire rd_hit_sta = raddr == `ADDR_CLOCK_STATUS;
    wire rd_ok = rd_hit_div || rd_hit_ctl || rd_hit_sta;
    wire [31:0] rd_mux = rd_hit_div ? rd_div : rd_hit_ctl ? rd_ctl : rd_hit_sta ? rd_sta : 32'h0;

    // read data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================
    // postscaler
    wire src_tick = (src_reg == src_pll) ? pll_clk_tick : master_clk_tick;
    // divide code to full-period mask: 2^code ticks per period, 256 for codes eight and up
    logic [7:0] code_mask;
    always_comb begin
        code_mask = 8'h00;
        if (cfg_reg.postscale_divide[3]) begin
            code_mask = 8'hff;
        end else begin
            code_mask = 8'(({8'h00, 8'h01} << cfg_reg.postscale_divide[2:0]) - 16'h1);
        end
    end
    wire period_end = src_tick && ((pcnt_reg & active_mask_reg) == active_mask_reg);
    wire bypass = active_mask_reg == 8'h00;

    // period counter, ratio swaps only at a full period end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcnt_reg <= 8'h00;
            active_mask_reg <= 8'h00;
            out_level_reg <= 1'b0;
        end else if (period_end) begin
            pcnt_reg <= 8'h00;
            active_mask_reg <= code_mask;
            out_level_reg <= 1'b0;
        end else if (src_tick) begin
            pcnt_reg <= pcnt_reg + 8'h01;
            if (pcnt_reg == (active_mask_reg >> 1)) begin
                out_level_reg <= 1'b1; // second half of period
            end
        end
    end
    assign core_clk_en = bypass ? src_tick : period_end;
    assign core_clk_level = out_level_reg;

    // ==========================================
    // loss of reference detector
    // limit = (trip+1)*10*(MULT/2) pll ticks, equal to the ref-period form
    wire [CW-1:0] lim = CW'((int'(cfg_reg.loss_ref_trip_point) + 1)
        * `LOSS_REF_PERIODS * HALF_MULT);
    wire lost_hit = lcnt_reg >= lim;

    // count pll ticks since last reference edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lcnt_reg <= '0;
        end else if (ref_clk_edge) begin
            lcnt_reg <= '0;
        end else if (pll_clk_tick && !lost_hit) begin
            lcnt_reg <= lcnt_reg + CW'(1);
        end
    end

    // sticky flag, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lost_reg <= 1'b0;
        end else if (lost_hit) begin
            lost_reg <= 1'b1;
        end else if (lost_clr) begin
            lost_reg <= 1'b0;
        end
    end
    assign lost_reference_flag = lost_reg;

    // ==========================================
    // bus outputs
    // write side ready while nothing held and no answer waits
    assign s_axi_awready = !have_aw_reg && !bvalid_reg;
    assign s_axi_wready = !have_w_reg && !bvalid_reg;
    // write answer
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    // read side ready while no answer waits
    assign s_axi_arready = !rvalid_reg;
    // read answer
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule

// File: clk_ps_assertions.sv
// port checker of the postscaler block
`timescale 1ns/1ns
module clk_ps_assertions #(parameter int MULT = 24) (
    // bus handshakes
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // clock sources and outputs
    input wire logic master_clk_tick, pll_clk_tick, ref_clk_edge,
    input wire logic core_clk_en, core_clk_level, lost_reference_flag
);
    localparam int LO = MULT * 5 - 1;
    localparam int HI = MULT * 80 + 3;
    logic [11:0] cnt_reg;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // pll ticks since the last reference edge
    always_ff @(posedge aclk) begin
        if (!aresetn || ref_clk_edge) cnt_reg <= 12'h000;
        else if (pll_clk_tick && cnt_reg != 12'hfff) cnt_reg <= cnt_reg + 12'h001;
    end
    // ==========================================
    // handshakes, answers and outputs
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_en_source: assert property (core_clk_en |-> master_clk_tick || pll_clk_tick)
        else $error("core enable without tick");
    chk_level_clean: assert property ($changed(core_clk_level)
        |-> $past(master_clk_tick) || $past(pll_clk_tick))
        else $error("level moved off a tick");
    chk_loss_early: assert property ($rose(lost_reference_flag) |-> cnt_reg >= LO)
        else $error("loss flagged too early");
    chk_loss_late: assert property (cnt_reg >= HI |=> lost_reference_flag)
        else $error("loss flagged too late");
endmodule
bind clock_postscaler_loss_ref_trip clk_ps_assertions #(.MULT(MULT)) u_chk (.*);

// File: clock_postscaler_loss_ref_trip_test.sv
// self-checking bench of the postscaler block
`timescale 1ns/1ns
module clock_postscaler_loss_ref_trip_test;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, master_clk_tick = 1, pll_clk_tick = 0;
    logic ref_clk_edge = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, core_clk_en, core_clk_level, lost_reference_flag;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h4cdd, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_total = 0, check_count = 0, n, t, h;
    clock_postscaler_loss_ref_trip u_dut (.*);
    initial forever #4 aclk = ~aclk;
    // ==========================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // expected ticks per period and high ticks per period of a divide code
    function automatic logic [31:0] exp_per(input int c);
        return c > 7 ? 32'h100 : 32'h1 << c;
    endfunction
    function automatic logic [31:0] exp_high(input int c);
        return c == 0 ? 32'h0 : exp_per(c) >> 1;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    // read one word and compare data and response
    task automatic rc(input logic [5:0] a, input logic [31:0] v, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, v, "read data");
        chk(32'(s_axi_rresp), 32'(r), "read resp");
    endtask
    // cycles between two core enable pulses
    task automatic per(output int k, output int hk);
        k = 0;
        hk = 0;
        do @(posedge aclk); while (!core_clk_en);
        do begin
            @(posedge aclk);
            k++;
            if (core_clk_level === 1'b1) hk++;
        end while (!core_clk_en);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rc(6'h04, 32'h0, 2'h0);
        rc(6'h00, 32'h1, 2'h0);
        rc(6'h08, 32'h1, 2'h0);
        rc(6'h0c, 32'h0, 2'h2);
        wr(6'h10, 32'h1);
        chk(32'(rsp), 32'h2, "unmapped write");
        $display("test registers done");
        // every code on the fly, random trip and reserved bits
        for (int c = 0; c < 16; c++) begin
            seed = xs(seed);
            d = {16'h0, seed[3:0], 4'(c), seed[11:4]};
            wr(6'h04, d);
            rc(6'h04, d & 32'h0000ff00, 2'h0);
            per(n, h);
            per(n, h);
            chk(32'(n), exp_per(c), "divide period");
            chk(32'(h), exp_high(c), "level high time");
        end
        $display("test divide done");
        // pll chosen: master ticks blocked, reserved codes kept out
        wr(6'h04, 32'h0);
        wr(6'h00, 32'h2);
        repeat (20) begin
            @(posedge aclk);
            chk(32'(core_clk_en), 32'h0, "master leaks");
        end
        wr(6'h00, 32'h3);
        rc(6'h08, 32'h2, 2'h0);
        pll_clk_tick <= 1'h1;
        master_clk_tick <= 1'h0;
        per(n, h);
        chk(32'(n), 32'h1, "pll period");
        wr(6'h00, 32'h1);
        master_clk_tick <= 1'h1;
        rc(6'h00, 32'h1, 2'h0);
        $display("test source done");
        // loss of reference at three trip points, sticky until cleared
        for (int i = 0; i < 3; i++) begin
            t = i * 7 + (i == 2);
            wr(6'h04, {16'h0, 4'(t), 12'h0});
            ref_clk_edge <= 1'h0;
            repeat ((t + 1) * 120 - 3) @(posedge aclk);
            chk(32'(lost_reference_flag), 32'h0, "early loss");
            repeat (6) @(posedge aclk);
            chk(32'(lost_reference_flag), 32'h1, "late loss");
            ref_clk_edge <= 1'h1;
            rc(6'h08, 32'h2001, 2'h0);
            wr(6'h08, 32'h2000);
            rc(6'h08, 32'h1, 2'h0);
        end
        $display("test loss done");
        end_of_test;
    end
    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge aclk);
        err_total++;
        end_of_test;
    end
endmodule
